/* File: pkg/vrs_map.svh */
/*
 * Command codes, field positions, reset values and timing figures of the
 * regulator supervisor.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef VRS_MAP_SVH
`define VRS_MAP_SVH

// command codes
`define VRS_CMD_CFG_A 8'hD2
`define VRS_CMD_CFG_B 8'hD3
`define VRS_CMD_TON_DELAY 8'hD4
`define VRS_CMD_ILIM_TRIM 8'hE2
`define VRS_CMD_PG_HIGH 8'hE3
`define VRS_CMD_LOAD_TH1 8'hE4
`define VRS_CMD_LOAD_TH2 8'hE5
`define VRS_CMD_LOAD_TH3 8'hE6
`define VRS_CMD_LOAD_OFF1 8'hE8
`define VRS_CMD_CUR_READ 8'h8C

// field positions
`define VRS_LATCHOFF_EN_BIT 1
`define VRS_TRIM_MSB 4
`define VRS_TON_MSB 2

// reset values and limit trim base
`define VRS_RST_CFG 8'h02
`define VRS_RST_TON 8'h03
`define VRS_RST_TRIM 8'h10
`define VRS_RST_PG_HIGH 8'hC0
`define VRS_RST_LOAD_TH 8'h00
`define VRS_RST_LOAD_OFF 8'h00
`define VRS_TRIM_BASE 6'h10

// timing
`define VRS_CLK_NS 40
`define VRS_DELAY_STEP_NS 500000
`define VRS_BLANK_NS 100000
`define VRS_LATCH_MULT 4

// address choice: lowest level of each band in mV and base address
`define VRS_ADDR_BASE 8'hC0
`define VRS_ADDR_BANDS {12'd2000, 12'd1500, 12'd1100, 12'd800, 12'd550, 12'd300, 12'd150}

`endif

/* File: pkg/vrs_pkg.sv */
/*
 * Types of the regulator supervisor: sequencing states and the packed
 * state record of the design module.
 * Assumes vrs_map.svh is on the include path.
 */
package vrs_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_FIRST_DELAY,
      ST_RAMP,
      ST_PG_DELAY,
      ST_RUN,
      ST_LATCHED
   } vrs_seq_e;

   typedef struct packed {
      logic [15:0] sy1;
      logic [15:0] sy2;
      logic [7:0] code_seen;
      vrs_seq_e seq;
      logic [19:0] tmr;
      logic [19:0] lat;
      logic [11:0] blank;
      logic crow;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] ton;
      logic [7:0] trim;
      logic [7:0] pg_high;
      logic [2:0][7:0] load_th;
      logic [3:0][7:0] load_off;
      logic [1:0] load_state;
      logic [7:0] rdata;
      logic [7:0] bus_addr;
      logic pwm_en;
      logic pg;
      logic fixed_en;
      logic shed_en;
   } vrs_state_s;

endpackage : vrs_pkg

/* File: hdl/vrs_supervisor.sv */
/*
 * Fault and supervision logic of a multiphase regulator controller:
 * current-limit latch-off, power-good with code-change blanking, crowbar,
 * phase shedding, enable/lockout gating, load-dependent offset and bus
 * address choice, with a command-code register port.
 * Assumes a bus engine on mclk that gives one-cycle write and read strobes,
 * asynchronous comparator and pin inputs, and converter readings on mclk.
 */
`timescale 1ns/1ns
`include "vrs_map.svh"

// How it works
// - five-bit limit trim at command E2
// - limit runs 50% to 146.9%, default 100%
// - limit after power-good delay starts latch-off timer
// - latch-off time is four start-up delays
// - start-up limit waits through all delay phases
// - phases keep running; clearing fault cancels timer
// - enable pulsed low clears latched shutdown
// - latch-off bit cleared in both disables latch
// - power-good low: outside window, no-processor, disabled
// - code change blanks power-good fault 100 us
// - power-good waits for ramp and delay
// - low-power request low drops shed driver enable
// - overvoltage outside code-change blanking forces outputs low until release level
// - crowbar level follows power-good upper limit
// - start only with enable and no lockout
// - disabled: outputs, power-good, driver enables low
// - readback command returns output current in amperes
// - thresholds three, two, one pick load state
// - four offset registers, each reset zero
// - register port answers only to external master
// - bus address C0..CE from address-pin band
// - three-bit delay code, 0.5 to 4 ms
// - each code change restarts blanking timer
module vrs_supervisor #(
   parameter int DELAY_STEP_CYC = `VRS_DELAY_STEP_NS / `VRS_CLK_NS,
   parameter logic [7:0] LOAD_TH1_RST = `VRS_RST_LOAD_TH,
   parameter logic [7:0] LOAD_TH2_RST = `VRS_RST_LOAD_TH,
   parameter logic [7:0] LOAD_TH3_RST = `VRS_RST_LOAD_TH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port from the bus engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_cmd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // pins and comparators, asynchronous
   input wire logic chip_enable,
   input wire logic supply_undervoltage_lockout,
   input wire logic ilim_reached,
   input wire logic above_crowbar,
   input wire logic below_release,
   input wire logic output_sense_in_window,
   input wire logic no_processor_code,
   input wire logic low_power_request_n,
   input wire logic [7:0] voltage_code,
   // ramp generator and converter readings, on mclk
   input wire logic ss_at_target,
   input wire logic [7:0] output_current_amps,
   input wire logic [11:0] addr_pin_mv,
   // analog settings out
   output logic [5:0] ilim_scale_32nds,
   output logic [7:0] crowbar_level,
   output logic [7:0] load_offset,
   output logic [1:0] load_state,
   output logic [7:0] bus_address,
   output logic soft_start_run,
   // protection outputs
   output logic pwm_enable,
   output logic output_in_range,
   output logic fixed_phase_driver_enable_n,
   output logic shed_phase_driver_enable_n
);

   localparam int BLANK_CYC = `VRS_BLANK_NS / `VRS_CLK_NS;
   localparam logic [11:0] BLANK_LOAD = 12'(BLANK_CYC);
   localparam logic [83:0] ADDR_BANDS = `VRS_ADDR_BANDS;
   localparam vrs_pkg::vrs_state_s RST = '{
      sy1: '0, sy2: '0, code_seen: '0, seq: vrs_pkg::ST_OFF, tmr: '0, lat: '0,
      blank: '0, crow: 1'b0, cfg_a: `VRS_RST_CFG, cfg_b: `VRS_RST_CFG,
      ton: `VRS_RST_TON, trim: `VRS_RST_TRIM, pg_high: `VRS_RST_PG_HIGH,
      load_th: {LOAD_TH3_RST, LOAD_TH2_RST, LOAD_TH1_RST},
      load_off: {4{`VRS_RST_LOAD_OFF}}, load_state: 2'h0, rdata: 8'h00,
      bus_addr: `VRS_ADDR_BASE, pwm_en: 1'b0, pg: 1'b0, fixed_en: 1'b0,
      shed_en: 1'b0};

   vrs_pkg::vrs_state_s q;
   vrs_pkg::vrs_state_s d;

   // synchronised views
   logic en_s;
   logic lockout_s;
   logic ilim_s;
   logic ovp_s;
   logic rel_s;
   logic win_s;
   logic nocpu_s;
   logic lp_n_s;
   logic [7:0] code_s;
   logic active_ok;
   logic latchoff_en;
   logic code_chg;
   logic blanking;
   logic [19:0] delay_cyc;
   logic [19:0] latch_cyc;

   // address from the pin level: bands rise with i, highest band passed wins
   function automatic logic [7:0] addr_of(input logic [11:0] mv);
      logic [7:0] a;
      a = `VRS_ADDR_BASE;
      for (int i = 0; i < 7; i++) begin
         if (mv >= ADDR_BANDS[i*12 +: 12]) begin
            a = `VRS_ADDR_BASE + 8'(2 * (i + 1));
         end
      end
      return a;
   endfunction : addr_of

   function automatic logic [7:0] read_of(input vrs_pkg::vrs_state_s s,
                                          input logic [7:0] cmd,
                                          input logic [7:0] amps);
      logic [7:0] r;
      r = 8'h00;
      unique case (cmd)
         `VRS_CMD_CFG_A: r = s.cfg_a;
         `VRS_CMD_CFG_B: r = s.cfg_b;
         `VRS_CMD_TON_DELAY: r = s.ton;
         `VRS_CMD_ILIM_TRIM: r = s.trim;
         `VRS_CMD_PG_HIGH: r = s.pg_high;
         `VRS_CMD_LOAD_TH1: r = s.load_th[0];
         `VRS_CMD_LOAD_TH2: r = s.load_th[1];
         `VRS_CMD_LOAD_TH3: r = s.load_th[2];
         `VRS_CMD_CUR_READ: r = amps;
         default: begin
            if (cmd >= `VRS_CMD_LOAD_OFF1 && cmd <= `VRS_CMD_LOAD_OFF1 + 8'h03) begin
               r = s.load_off[2'(cmd - `VRS_CMD_LOAD_OFF1)];
            end
         end
      endcase
      return r;
   endfunction : read_of

   assign {code_s, lp_n_s, nocpu_s, win_s, rel_s, ovp_s, ilim_s, lockout_s, en_s} = q.sy2;
   assign active_ok = en_s && !lockout_s;
   assign latchoff_en = q.cfg_a[`VRS_LATCHOFF_EN_BIT] || q.cfg_b[`VRS_LATCHOFF_EN_BIT];
   assign code_chg = (code_s != q.code_seen);
   assign blanking = (q.blank != 12'h000);
   assign delay_cyc = 20'((q.ton[`VRS_TON_MSB:0] + 4'h1) * DELAY_STEP_CYC);
   assign latch_cyc = 20'(`VRS_LATCH_MULT * delay_cyc);

   always_comb begin
      d = q;
      d.sy1 = {voltage_code, low_power_request_n, no_processor_code, output_sense_in_window,
               below_release, above_crowbar, ilim_reached, supply_undervoltage_lockout,
               chip_enable};
      d.sy2 = q.sy1;
      d.code_seen = code_s;
      // registers written only by the outside master
      if (reg_wr) begin
         unique case (reg_cmd)
            `VRS_CMD_CFG_A: d.cfg_a = reg_wdata;
            `VRS_CMD_CFG_B: d.cfg_b = reg_wdata;
            `VRS_CMD_TON_DELAY: d.ton = {5'h00, reg_wdata[`VRS_TON_MSB:0]};
            `VRS_CMD_ILIM_TRIM: d.trim = {3'h0, reg_wdata[`VRS_TRIM_MSB:0]};
            `VRS_CMD_PG_HIGH: d.pg_high = reg_wdata;
            `VRS_CMD_LOAD_TH1: d.load_th[0] = reg_wdata;
            `VRS_CMD_LOAD_TH2: d.load_th[1] = reg_wdata;
            `VRS_CMD_LOAD_TH3: d.load_th[2] = reg_wdata;
            default: begin
               if (reg_cmd >= `VRS_CMD_LOAD_OFF1 && reg_cmd <= `VRS_CMD_LOAD_OFF1 + 8'h03) begin
                  d.load_off[2'(reg_cmd - `VRS_CMD_LOAD_OFF1)] = reg_wdata;
               end
            end
         endcase
      end
      if (reg_rd) begin
         d.rdata = read_of(q, reg_cmd, output_current_amps);
      end
      // blanking restarts on every code change
      if (code_chg) begin
         d.blank = BLANK_LOAD;
      end else if (blanking) begin
         d.blank = q.blank - 12'h001;
      end
      // start-up sequence and latch-off
      d.tmr = q.tmr + 20'h00001;
      d.lat = 20'h00000;
      unique case (q.seq)
         vrs_pkg::ST_OFF: begin
            d.tmr = 20'h00000;
            if (active_ok) d.seq = vrs_pkg::ST_FIRST_DELAY;
         end
         vrs_pkg::ST_FIRST_DELAY: begin
            if (q.tmr >= delay_cyc - 20'h00001) d.seq = vrs_pkg::ST_RAMP;
         end
         vrs_pkg::ST_RAMP: begin
            d.tmr = 20'h00000;
            if (ss_at_target) d.seq = vrs_pkg::ST_PG_DELAY;
         end
         vrs_pkg::ST_PG_DELAY: begin
            if (q.tmr >= delay_cyc - 20'h00001) d.seq = vrs_pkg::ST_RUN;
         end
         vrs_pkg::ST_RUN: begin
            d.tmr = 20'h00000;
            if (ilim_s) begin
               d.lat = q.lat + 20'h00001;
               if (latchoff_en && q.lat >= latch_cyc - 20'h00001) begin
                  d.seq = vrs_pkg::ST_LATCHED;
               end
            end
            // fault gone: timer restarts from zero and phases never stopped
         end
         vrs_pkg::ST_LATCHED: d.tmr = 20'h00000;
         default: d.seq = vrs_pkg::ST_OFF;
      endcase
      if (!active_ok) begin
         d.seq = vrs_pkg::ST_OFF;
      end
      // crowbar: level set by the power-good upper limit
      if (!active_ok) begin
         d.crow = 1'b0;
      end else if (ovp_s && !blanking) begin
         d.crow = 1'b1;
      end else if (rel_s) begin
         d.crow = 1'b0;
      end
      // load state from the highest threshold down
      if (output_current_amps > q.load_th[2]) d.load_state = 2'h3;
      else if (output_current_amps > q.load_th[1]) d.load_state = 2'h2;
      else if (output_current_amps > q.load_th[0]) d.load_state = 2'h1;
      else d.load_state = 2'h0;
      d.bus_addr = addr_of(addr_pin_mv);
      // outputs
      d.pwm_en = active_ok && !d.crow && d.seq != vrs_pkg::ST_OFF
                 && d.seq != vrs_pkg::ST_LATCHED && d.seq != vrs_pkg::ST_FIRST_DELAY;
      d.pg = active_ok && q.seq == vrs_pkg::ST_RUN && d.seq == vrs_pkg::ST_RUN
             && (win_s || blanking) && !nocpu_s;
      d.fixed_en = active_ok && d.seq != vrs_pkg::ST_LATCHED;
      d.shed_en = d.fixed_en && lp_n_s;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign ilim_scale_32nds = `VRS_TRIM_BASE + {1'b0, q.trim[`VRS_TRIM_MSB:0]};
   assign crowbar_level = q.pg_high;
   assign load_offset = q.load_off[q.load_state];
   assign load_state = q.load_state;
   assign bus_address = q.bus_addr;
   assign soft_start_run = (q.seq == vrs_pkg::ST_RAMP || q.seq == vrs_pkg::ST_PG_DELAY
                            || q.seq == vrs_pkg::ST_RUN);
   assign pwm_enable = q.pwm_en;
   assign output_in_range = q.pg;
   assign fixed_phase_driver_enable_n = q.fixed_en;
   assign shed_phase_driver_enable_n = q.shed_en;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_pg_delay_done;
      q.seq == vrs_pkg::ST_PG_DELAY ##1 q.seq == vrs_pkg::ST_RUN;
   endsequence

   a_trim_write: assert property (reg_wr && reg_cmd == `VRS_CMD_ILIM_TRIM
      |=> ilim_scale_32nds == `VRS_TRIM_BASE + {1'b0, $past(reg_wdata[4:0])})
      else $error("trim write not applied");
   a_run_entry: assert property (q.seq == vrs_pkg::ST_RUN && active_ok
      && $past(q.seq) != vrs_pkg::ST_RUN |-> $past(q.seq) == vrs_pkg::ST_PG_DELAY)
      else $error("run entered without power-good delay");
   a_latch_expiry: assert property (q.seq == vrs_pkg::ST_RUN && ilim_s && latchoff_en
      && active_ok && q.lat == latch_cyc - 20'h00001 |=> q.seq == vrs_pkg::ST_LATCHED)
      else $error("latch-off did not fire at expiry");
   a_no_latch_dis: assert property (q.seq == vrs_pkg::ST_RUN && !latchoff_en
      |=> q.seq != vrs_pkg::ST_LATCHED)
      else $error("latched while latch-off disabled");
   a_enable_clear: assert property (q.seq == vrs_pkg::ST_LATCHED && !en_s
      |=> q.seq == vrs_pkg::ST_OFF ##1 !pwm_enable)
      else $error("latched state not cleared by enable");
   a_off_outputs: assert property (!active_ok
      |=> !pwm_enable && !output_in_range && !fixed_phase_driver_enable_n
          && !shed_phase_driver_enable_n)
      else $error("outputs active while disabled");
   a_shed_low: assert property (!lp_n_s |=> !shed_phase_driver_enable_n)
      else $error("shed driver enable high in low power");
   a_crowbar_pwm: assert property (q.crow |-> !pwm_enable)
      else $error("outputs switching during crowbar");
   a_blank_restart: assert property (code_chg |=> q.blank == BLANK_LOAD)
      else $error("blanking not restarted");
   a_pg_after_delay: assert property ($rose(output_in_range)
      |-> $past(q.seq, 2) == vrs_pkg::ST_RUN || $past(q.seq, 2) == vrs_pkg::ST_PG_DELAY)
      else $error("power-good rose outside run");
   a_pg_sequence: assert property (s_pg_delay_done |-> !output_in_range)
      else $error("power-good high on run entry");
   a_load_select: assert property (output_current_amps > q.load_th[2]
      |=> load_state == 2'h3)
      else $error("load state not highest");

endmodule : vrs_supervisor

/* File: test/vrs_plant.sv */
/*
 * Behavioural regulator plant: soft-start ramp that reaches its target a
 * fixed time after the supervisor lets it run, and a window comparator
 * the bench can disturb.
 * Assumes the supervisor's soft_start_run output and mclk/nrst of the bench.
 */
`timescale 1ns/1ns
module vrs_plant (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // control from supervisor and bench
   input wire logic soft_start_run,
   input wire logic disturb,
   // plant state back to the supervisor
   output logic ss_at_target,
   output logic output_sense_in_window
);
   logic [3:0] ramp_q;

   // ramp restarts whenever the supervisor stops running
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ramp_q <= 4'h0;
      end else if (!soft_start_run) begin
         ramp_q <= 4'h0;
      end else if (ramp_q != 4'h8) begin
         ramp_q <= ramp_q + 4'h1;
      end
   end

   assign ss_at_target = (ramp_q == 4'h8);
   assign output_sense_in_window = ss_at_target && !disturb;
endmodule : vrs_plant

/* File: test/vrs_supervisor_bench.sv */
/*
 * Self-checking bench of the regulator supervisor with a plant model.
 * Assumes the design with a short delay step and the vrs_plant model.
 */
`timescale 1ns/1ns
module vrs_supervisor_bench;
   localparam int STEP = 10;
   localparam int LAT = 4 * STEP;
   localparam logic [11:0] MV [8] = '{12'h095, 12'h096, 12'h225, 12'h226,
                                      12'h44B, 12'h44C, 12'h7CF, 12'h7D0};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_cmd = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic chip_enable = 1'b0;
   logic supply_undervoltage_lockout = 1'b0;
   logic ilim_reached = 1'b0;
   logic above_crowbar = 1'b0;
   logic below_release = 1'b0;
   logic no_processor_code = 1'b0;
   logic low_power_request_n = 1'b1;
   logic [7:0] voltage_code = 8'h00;
   logic [7:0] output_current_amps = 8'h00;
   logic [11:0] addr_pin_mv = 12'h000;
   logic disturb = 1'b0;
   logic ss_at_target, output_sense_in_window, soft_start_run;
   logic [7:0] reg_rdata, crowbar_level, load_offset, bus_address;
   logic [5:0] ilim_scale_32nds;
   logic [1:0] load_state;
   logic pwm_enable, output_in_range;
   logic fixed_phase_driver_enable_n, shed_phase_driver_enable_n;
   logic rd_d = 1'b0;
   logic [7:0] exp_q [$];
   int n_errors = 0;
   int comparisons = 0;

   vrs_supervisor #(.DELAY_STEP_CYC(STEP)) DUT (.mclk(mclk), .nrst(nrst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .chip_enable(chip_enable),
      .supply_undervoltage_lockout(supply_undervoltage_lockout),
      .ilim_reached(ilim_reached), .above_crowbar(above_crowbar),
      .below_release(below_release), .output_sense_in_window(output_sense_in_window),
      .no_processor_code(no_processor_code), .low_power_request_n(low_power_request_n),
      .voltage_code(voltage_code), .ss_at_target(ss_at_target),
      .output_current_amps(output_current_amps), .addr_pin_mv(addr_pin_mv),
      .ilim_scale_32nds(ilim_scale_32nds), .crowbar_level(crowbar_level),
      .load_offset(load_offset), .load_state(load_state), .bus_address(bus_address),
      .soft_start_run(soft_start_run), .pwm_enable(pwm_enable),
      .output_in_range(output_in_range),
      .fixed_phase_driver_enable_n(fixed_phase_driver_enable_n),
      .shed_phase_driver_enable_n(shed_phase_driver_enable_n));

   vrs_plant plant (.mclk(mclk), .nrst(nrst), .soft_start_run(soft_start_run),
      .disturb(disturb), .ss_at_target(ss_at_target),
      .output_sense_in_window(output_sense_in_window));

   always #20 mclk = ~mclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // protection outputs packed as pwm, power-good, fixed, shed
   function automatic logic [7:0] outs();
      return {4'h0, pwm_enable, output_in_range, fixed_phase_driver_enable_n,
              shed_phase_driver_enable_n};
   endfunction : outs

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tick

   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_cmd = c;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      reg_rd = 1'b1;
      reg_cmd = c;
      exp_q.push_back(e);
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask : rd

   task automatic wt(input logic [7:0] m, output int n);
      for (n = 0; n < 400 && (outs() & m) !== m; n++) tick(1);
   endtask : wt

   task automatic final_report;
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report

   // read data lands one cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      rd_d <= reg_rd;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      final_report;
   end

   initial begin
      int n;
      logic [31:0] r;
      logic [7:0] t;
      r = 32'h2689;
      repeat (6) @(posedge mclk);
      #2 nrst = 1'b1;
      tick(1);
      rd(8'hE2, 8'h10);
      rd(8'hD2, 8'h02);
      rd(8'hD3, 8'h02);
      rd(8'hD4, 8'h03);
      rd(8'h55, 8'h00);
      for (int i = 0; i < 4; i++) rd(8'(8'hE8 + i), 8'h00);
      chk("ilim_scale", 8'h20, {2'b00, ilim_scale_32nds});
      chk("crowbar_level", 8'hC0, crowbar_level);
      for (int i = 0; i < 4; i++) begin
         r = xs(r);
         wr(8'hE2, r[7:0]);
         chk("ilim_scale", 8'h10 + {3'b000, r[4:0]}, {2'b00, ilim_scale_32nds});
         rd(8'hE2, {3'b000, r[4:0]});
      end
      wr(8'hE3, 8'hB7);
      chk("crowbar_level", 8'hB7, crowbar_level);
      for (int i = 0; i < 8; i++) begin
         addr_pin_mv = MV[i];
         tick(3);
         chk("bus_address", 8'(8'hC0 + 2 * i), bus_address);
      end
      wr(8'hE4, 8'h10);
      wr(8'hE5, 8'h20);
      wr(8'hE6, 8'h30);
      for (int i = 0; i < 4; i++) wr(8'(8'hE8 + i), 8'(8'h11 * (i + 1)));
      for (int i = 0; i < 4; i++) begin
         r = xs(r);
         t = 8'(8'h10 * i + 1 + r[2:0]);
         output_current_amps = t;
         tick(3);
         chk("load_state", 8'(i), {6'h00, load_state});
         chk("load_offset", 8'(8'h11 * (i + 1)), load_offset);
         rd(8'h8C, t);
      end
      wr(8'hD4, 8'hF8);
      rd(8'hD4, 8'h00);
      supply_undervoltage_lockout = 1'b1;
      chip_enable = 1'b1;
      tick(60);
      chk("outs_lockout", 8'h00, outs());
      supply_undervoltage_lockout = 1'b0;
      wt(8'h08, n);
      chk("pg_early", 8'h08, outs() & 8'h0C);
      wt(8'h04, n);
      chk("pg_wait", 8'h01, 8'(n >= 17));
      chk("outs_run", 8'h0F, outs());
      chk("soft_start_run", 8'h01, {7'h00, soft_start_run});
      low_power_request_n = 1'b0;
      tick(4);
      chk("outs_low_power", 8'h0E, outs());
      low_power_request_n = 1'b1;
      no_processor_code = 1'b1;
      tick(4);
      chk("outs_no_proc", 8'h0B, outs());
      no_processor_code = 1'b0;
      tick(4);
      r = xs(r);
      voltage_code = voltage_code ^ (r[7:0] | 8'h01);
      tick(4);
      disturb = 1'b1;
      tick(1500);
      chk("pg_blank", 8'h04, outs() & 8'h04);
      voltage_code = ~voltage_code;
      tick(2000);
      chk("pg_reblank", 8'h04, outs() & 8'h04);
      tick(700);
      chk("pg_window", 8'h00, outs() & 8'h04);
      disturb = 1'b0;
      tick(4);
      chk("pg_back", 8'h04, outs() & 8'h04);
      above_crowbar = 1'b1;
      tick(1);
      above_crowbar = 1'b0;
      tick(4);
      chk("pwm_crowbar", 8'h00, outs() & 8'h08);
      tick(20);
      chk("pwm_crowbar", 8'h00, outs() & 8'h08);
      below_release = 1'b1;
      tick(4);
      below_release = 1'b0;
      chk("pwm_release", 8'h08, outs() & 8'h08);
      ilim_reached = 1'b1;
      tick(LAT - 10);
      ilim_reached = 1'b0;
      tick(2);
      ilim_reached = 1'b1;
      tick(LAT - 8);
      chk("pwm_limit", 8'h08, outs() & 8'h08);
      tick(18);
      chk("outs_latched", 8'h00, outs());
      chk("soft_start_run", 8'h00, {7'h00, soft_start_run});
      wr(8'hD2, 8'h00);
      chip_enable = 1'b0;
      tick(3);
      chip_enable = 1'b1;
      wt(8'h04, n);
      chk("pg_restart", 8'h04, outs() & 8'h04);
      tick(LAT + 10);
      chk("outs_latched", 8'h00, outs());
      wr(8'hD3, 8'h00);
      chip_enable = 1'b0;
      tick(3);
      chip_enable = 1'b1;
      wt(8'h04, n);
      tick(LAT + 40);
      chk("pwm_no_latch", 8'h08, outs() & 8'h08);
      ilim_reached = 1'b0;
      chip_enable = 1'b0;
      tick(4);
      chk("outs_disabled", 8'h00, outs());
      tick(2);
      final_report;
   end
endmodule : vrs_supervisor_bench
